// [core/sbsc_pkg.sv]
package sbsc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int DEPTH = 256;
   localparam int BURST_W = 2;
   localparam logic [1:0] BURST_LAST = 2'h3;
   localparam logic [1:0] SLEEP_LAT = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [2:0] CMD_NONE = 3'h0;
   // sleep exit recovery, host-side limit only
   localparam int SLEEP_EXIT_NS = 100;
   localparam int CLK_NS = 50;
   localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      SB_ACTIVE = 2'b00,
      SB_ENTER = 2'b01,
      SB_SLEEP = 2'b10
   } sbsc_pwr_t;
endpackage

// [core/sbsc_burst_if.sv]
`timescale 1ns/100ps
interface sbsc_burst_if;
   import sbsc_pkg::*;
   logic load;
   logic step;
   logic order;
   logic [ADDR_W-1:0] ext_addr;
   logic [ADDR_W-1:0] cur_addr;
   modport ctl (output load, output step, output order, output ext_addr, input cur_addr);
   modport gen (input load, input step, input order, input ext_addr, output cur_addr);
endinterface

// [core/sbsc_burst_gen.sv]
`timescale 1ns/100ps
module sbsc_burst_gen
   import sbsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   sbsc_burst_if.gen bi
);
   logic [ADDR_W-1:0] base_r;
   logic [ADDR_W-1:0] base_nxt;
   logic [BURST_W-1:0] cnt_r;
   logic [BURST_W-1:0] cnt_nxt;
   logic [BURST_W-1:0] lin_low;
   logic [BURST_W-1:0] ilv_low;
   logic [BURST_W-1:0] low_sel;

   // ----------------------------
   // next-address arithmetic
   // ----------------------------
   assign lin_low = base_nxt[BURST_W-1:0] + cnt_nxt;
   assign ilv_low = base_nxt[BURST_W-1:0] ^ cnt_nxt;
   assign low_sel = bi.order ? ilv_low : lin_low;
   assign bi.cur_addr = {base_nxt[ADDR_W-1:BURST_W], low_sel};
   assign base_nxt = bi.load ? bi.ext_addr : base_r;
   assign cnt_nxt = bi.load ? '0 : (bi.step ? cnt_r + 2'h1 : cnt_r);

   always_ff @(posedge clk) begin
      if (rst) begin
         base_r <= ADDR_RST;
         cnt_r <= '0;
      end else begin
         base_r <= base_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [core/sbsc_top.sv]
// Function
// - a clock edge with the step select high during a selected burst advances the burst counter and uses its address.
// - a low step select loads the external address as the burst start.
// - after four addresses the counter wraps so the fifth repeats the first.
// - order select low gives linear order, high gives interleaved order.
// - linear adds the step modulo four, interleaved XORs the step with the low bits.
// - bypass low is flow-through, high (pulled up) is pipelined.
// - sleep request defaults low and places the device asleep on the fourth clock edge after rising.
// - sleep keeps memory contents and all control state but the read pipeline flags, which it clears.
// - asleep the device is deselected, ignores inputs and floats its data outputs.
// - sleep request is asynchronous, active high, and sleep lasts while it stays high.
// - the burst counter is two bits and acts on the low address bits.
// - clock gate high makes the device ignore the edge for accesses and hold their state; sleep entry and exit still proceed.
// - flow-through read latency is one cycle shorter than pipelined.
`timescale 1ns/100ps
module sbsc_top
   import sbsc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLOCK_GATE_N,
   input wire logic SELECT,
   input wire logic WRITE_N,
   input wire logic COUNTER_STEP_SELECT,
   input wire logic ORDER_SELECT,
   input wire logic OUTPUT_STAGE_BYPASS,
   input wire logic SLEEP_REQUEST,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] DQ_IN,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic DQ_OE,
   output logic SLEEPING
);
   sbsc_burst_if bif ();

   // ----------------------------
   // state and pipeline registers
   // ----------------------------
   logic sleep_s1_r;
   logic sleep_s2_r;
   sbsc_pwr_t pwr_r;
   sbsc_pwr_t pwr_nxt;
   logic [1:0] slp_cnt_r;
   logic [1:0] slp_cnt_nxt;
   logic active_r;
   logic active_nxt;
   logic [DATA_W-1:0] mem_r [DEPTH];
   logic rd1_r;
   logic rd2_r;
   logic [DATA_W-1:0] rdat1_r;
   logic [DATA_W-1:0] rdat2_r;
   logic wr1_r;
   logic wr2_r;
   logic [ADDR_W-1:0] wa1_r;
   logic [ADDR_W-1:0] wa2_r;
   logic go;
   logic awake;
   logic new_cmd;
   logic cont_cmd;
   logic acc;
   logic is_rd;
   logic is_wr;
   logic ft_mode;
   logic wr_commit;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] dq_nxt;
   logic oe_nxt;
   logic sleep_nxt;

   // ----------------------------
   // sleep request synchroniser and power state
   // ----------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         sleep_s1_r <= 1'b0;
         sleep_s2_r <= 1'b0;
      end else begin
         sleep_s1_r <= SLEEP_REQUEST;
         sleep_s2_r <= sleep_s1_r;
      end
   end

   always_comb begin
      pwr_nxt = pwr_r;
      slp_cnt_nxt = slp_cnt_r;
      unique case (pwr_r)
         SB_ACTIVE: begin
            slp_cnt_nxt = 2'h1;
            if (sleep_s2_r) begin
               pwr_nxt = SB_ENTER;
            end
         end
         SB_ENTER: begin
            slp_cnt_nxt = slp_cnt_r + 2'h1;
            if (!sleep_s2_r) begin
               pwr_nxt = SB_ACTIVE;
            end else if (slp_cnt_r == SLEEP_LAT - 2'h1) begin
               pwr_nxt = SB_SLEEP;
            end
         end
         SB_SLEEP: begin
            if (!sleep_s2_r) begin
               pwr_nxt = SB_ACTIVE;
            end
         end
         default: pwr_nxt = SB_ACTIVE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pwr_r <= SB_ACTIVE;
         slp_cnt_r <= 2'h1;
      end else begin
         pwr_r <= pwr_nxt;
         slp_cnt_r <= slp_cnt_nxt;
      end
   end

   // ----------------------------
   // command decode
   // ----------------------------
   assign awake = (pwr_r != SB_SLEEP);
   assign go = awake && !CLOCK_GATE_N;
   assign new_cmd = go && !COUNTER_STEP_SELECT && SELECT;
   assign cont_cmd = go && COUNTER_STEP_SELECT && active_r;
   assign acc = new_cmd || cont_cmd;
   assign is_rd = new_cmd ? WRITE_N : (cont_cmd && rd1_r);
   assign is_wr = acc && !is_rd;
   assign ft_mode = !OUTPUT_STAGE_BYPASS;
   assign active_nxt = !go ? active_r : (COUNTER_STEP_SELECT ? active_r : SELECT);

   // ----------------------------
   // burst generator
   // ----------------------------
   assign bif.load = go && !COUNTER_STEP_SELECT;
   assign bif.step = cont_cmd;
   assign bif.order = ORDER_SELECT;
   assign bif.ext_addr = ADDR;

   sbsc_burst_gen u_gen (
      .clk(CLK),
      .rst(RST),
      .bi(bif)
   );

   // ----------------------------
   // late-write commit and read stage select
   // ----------------------------
   function automatic logic stage_pick(input logic ft, input logic one, input logic two);
      return ft ? one : two;
   endfunction

   assign wr_commit = go && stage_pick(ft_mode, wr1_r, wr2_r);
   assign wr_addr = ft_mode ? wa1_r : wa2_r;
   assign dq_nxt = ft_mode ? rdat1_r : rdat2_r;
   assign sleep_nxt = (pwr_nxt == SB_SLEEP);
   assign oe_nxt = !sleep_nxt && stage_pick(ft_mode, rd1_r, rd2_r);

   // ----------------------------
   // access pipeline
   // ----------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         active_r <= 1'b0;
         rd1_r <= 1'b0;
         rd2_r <= 1'b0;
         wr1_r <= 1'b0;
         wr2_r <= 1'b0;
         wa1_r <= ADDR_RST;
         wa2_r <= ADDR_RST;
         rdat1_r <= DATA_RST;
         rdat2_r <= DATA_RST;
      end else if (go) begin
         active_r <= active_nxt;
         rd1_r <= acc && is_rd;
         wr1_r <= is_wr;
         wa1_r <= bif.cur_addr;
         rdat1_r <= mem_r[bif.cur_addr];
         rd2_r <= rd1_r;
         wr2_r <= wr1_r;
         wa2_r <= wa1_r;
         rdat2_r <= rdat1_r;
      end else if (!awake) begin
         rd1_r <= 1'b0;
         rd2_r <= 1'b0;
      end
   end

   // ----------------------------
   // memory array
   // ----------------------------
   always_ff @(posedge CLK) begin
      if (wr_commit) begin
         mem_r[wr_addr] <= DQ_IN;
      end
   end

   // ----------------------------
   // read data outputs
   // ----------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         DQ_OUT <= DATA_RST;
         DQ_OE <= 1'b0;
      end else begin
         if (go) begin
            DQ_OUT <= dq_nxt;
         end
         if (go || sleep_nxt) begin
            DQ_OE <= oe_nxt;
         end
      end
   end

   // ----------------------------
   // sleep status
   // ----------------------------
   assign SLEEPING = !awake;
endmodule

// [test/sbsc_top_assertions.sv]
`timescale 1ns/100ps
// ----
// sleep, stall and latency checks
// ----
module sbsc_chk
   import sbsc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLOCK_GATE_N,
   input wire logic SELECT,
   input wire logic WRITE_N,
   input wire logic COUNTER_STEP_SELECT,
   input wire logic OUTPUT_STAGE_BYPASS,
   input wire logic SLEEP_REQUEST,
   input wire logic [DATA_W-1:0] DQ_OUT,
   input wire logic DQ_OE,
   input wire logic SLEEPING
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   sequence s_rd(b);
      SELECT && WRITE_N && !COUNTER_STEP_SELECT && !CLOCK_GATE_N && !SLEEPING
         && !SLEEP_REQUEST && OUTPUT_STAGE_BYPASS == b;
   endsequence
   sequence s_held;
      $rose(SLEEP_REQUEST) ##1 SLEEP_REQUEST[*7];
   endsequence
   property p_rst_idle; $fell(RST) |-> !DQ_OE && !SLEEPING; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
   property p_float; SLEEPING |-> !DQ_OE; endproperty
   a_float: assert property (p_float) else $error("driving asleep");
   property p_late; $rose(SLEEP_REQUEST) |-> !SLEEPING ##1 !SLEEPING; endproperty
   a_late: assert property (p_late) else $error("sleep too early");
   property p_in; s_held |-> SLEEPING; endproperty
   a_in: assert property (p_in) else $error("no sleep");
   property p_out; $fell(SLEEP_REQUEST) ##1 !SLEEP_REQUEST[*5] |-> !SLEEPING; endproperty
   a_out: assert property (p_out) else $error("stuck asleep");
   property p_gate; CLOCK_GATE_N |=> $stable(DQ_OE) && $stable(DQ_OUT); endproperty
   a_gate: assert property (p_gate) else $error("stall moved output");
   property p_flow; s_rd(1'b0) ##1 !CLOCK_GATE_N |=> DQ_OE; endproperty
   a_flow: assert property (p_flow) else $error("flow read late");
   property p_pipe; s_rd(1'b1) ##1 !CLOCK_GATE_N[*2] |=> DQ_OE; endproperty
   a_pipe: assert property (p_pipe) else $error("pipe read late");
endmodule
bind sbsc_top sbsc_chk chk_u (.*);

// [test/sbsc_host.sv]
`timescale 1ns/100ps
// ----
// host controller model
// ----
module sbsc_host
   import sbsc_pkg::*;
(
   input wire logic clk,
   output logic gate_n,
   output logic sel,
   output logic wr_n,
   output logic step,
   output logic slp,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] din
);
   int seed = 82;
   initial begin
      {gate_n, sel, wr_n, step, slp} = 5'h04;
      addr = ADDR_RST;
      din = DATA_RST;
   end
   task cyc(input logic g, s, w, t, input logic [ADDR_W-1:0] a);
      @(posedge clk);
      {gate_n, sel, wr_n, step} <= {g, s, w, t};
      addr <= a;
      din <= DATA_W'($random(seed));
   endtask
   task nap(input logic [ADDR_W-1:0] a);
      cyc(1, 0, 1, 0, a);
      slp <= 1'b1;
      repeat (6) cyc(1, 0, 1, 0, a);
      repeat (3) cyc(0, 1, 1, 0, a);
      cyc(1, 0, 1, 0, a);
      slp <= 1'b0;
      repeat (SLEEP_EXIT_CYC + 4) cyc(1, 0, 1, 0, a);
   endtask
endmodule

// [test/sbsc_top_tb.sv]
`timescale 1ns/100ps
// ----
// bench with burst and pipeline model
// ----
module sbsc_top_tb;
   import sbsc_pkg::*;
   logic clk = 0, rst = 1, bp = 1, ord = 0, g, s, w, t, z, oe, slpg, eoe, act, dir;
   logic [ADDR_W-1:0] a, b, base, ea;
   logic [DATA_W-1:0] d, dq, edq;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] rd [2];
   logic [ADDR_W-1:0] wa [2];
   logic rv [2], wv [2];
   logic [1:0] k;
   int checked = 0, miscompares = 0;
   always #25 clk = ~clk;
   sbsc_host host_u (.clk(clk), .gate_n(g), .sel(s), .wr_n(w), .step(t), .slp(z),
      .addr(a), .din(d));
   sbsc_top dut_u (.CLK(clk), .RST(rst), .CLOCK_GATE_N(g), .SELECT(s), .WRITE_N(w),
      .COUNTER_STEP_SELECT(t), .ORDER_SELECT(ord), .OUTPUT_STAGE_BYPASS(bp),
      .SLEEP_REQUEST(z), .ADDR(a), .DQ_IN(d), .DQ_OUT(dq), .DQ_OE(oe), .SLEEPING(slpg));
   task chk(input logic c);
      checked++;
      if (c !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: read beat", $time);
      end
   endtask
   task end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rst) begin
         {rv[0], rv[1], wv[0], wv[1], eoe, act} = 6'h00;
      end else begin
         chk(oe === eoe && (!eoe || dq === edq));
         if (!g && !z) begin
            if (bp ? wv[1] : wv[0]) mem[bp ? wa[1] : wa[0]] = d;
            eoe = bp ? rv[1] : rv[0];
            edq = bp ? rd[1] : rd[0];
            {rv[1], rd[1], wv[1], wa[1]} = {rv[0], rd[0], wv[0], wa[0]};
            if (!t) begin
               {act, dir, base, k} = {s, w, a, 2'h0};
            end else begin
               k = k + 2'h1;
            end
            ea = {base[ADDR_W-1:2], ord ? base[1:0] ^ k : base[1:0] + k};
            {rv[0], rd[0], wv[0], wa[0]} = {act & dir, mem[ea], act & ~dir, ea};
         end
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         {ord, bp} <= m[1:0];
         b = ADDR_W'($random(host_u.seed));
         host_u.cyc(0, 1, 0, 0, b);
         repeat (4) host_u.cyc(0, 0, 0, 1, b);
         repeat (3) host_u.cyc(0, 0, 1, 0, b);
         host_u.cyc(0, 1, 1, 0, b);
         host_u.cyc(0, 0, 1, 1, b);
         host_u.cyc(1, 0, 1, 1, b);
         repeat (4) host_u.cyc(0, 0, 1, 1, b);
         repeat (3) host_u.cyc(0, 0, 1, 0, b);
      end
      host_u.nap(b);
      host_u.cyc(0, 1, 1, 0, b);
      repeat (4) host_u.cyc(0, 0, 1, 0, b);
      end_of_test;
   end
   initial begin
      #20000;
      miscompares++;
      end_of_test;
   end
endmodule
